/* octal_host_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "host_port_params.svh"

module octal_host_port #(
    parameter int CHANNELS = 8,
    parameter int REGS = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic bus_mode_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic cs_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [CHANNELS-1:0] chan_irq_i,
    output logic irq_n_o,
    output logic irq_n_oe_o,
    output logic wr_valid_o,
    output logic [CHANNELS-1:0] wr_chan_mask_o,
    output logic [3:0] wr_reg_o,
    output logic [7:0] wr_data_o
);

    // ****************************************
    // Elaboration check.
    // ****************************************
    if (CHANNELS != 8 || REGS != 16) begin : g_bad_size
        $error("The address map serves exactly eight channels of sixteen registers.");
    end

    // ****************************************
    // Strobe decoding.
    // ****************************************
    function automatic logic rd_level(input logic mode, input logic cs_n,
                                      input logic rd_n, input logic wr_n);
        if (mode) begin
            rd_level = !cs_n && !rd_n;
        end else begin
            rd_level = !cs_n && wr_n;
        end
    endfunction

    function automatic logic wr_level(input logic mode, input logic cs_n,
                                      input logic wr_n);
        if (mode) begin
            wr_level = !cs_n && !wr_n;
        end else begin
            wr_level = !cs_n && !wr_n;
        end
    endfunction

    logic rd_lvl;
    logic wr_lvl;
    logic rd_lvl_q;
    logic wr_lvl_q;
    logic rd_start;
    logic wr_start;

    always_comb begin
        rd_lvl = rd_level(bus_mode_i, cs_n_i, read_strobe_n_i, write_strobe_n_i);
        wr_lvl = wr_level(bus_mode_i, cs_n_i, write_strobe_n_i);
        rd_start = rd_lvl && !rd_lvl_q;
        wr_start = wr_lvl && !wr_lvl_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_lvl_q <= 1'b0;
            wr_lvl_q <= 1'b0;
        end else if (ce_i) begin
            rd_lvl_q <= rd_lvl;
            wr_lvl_q <= wr_lvl;
        end
    end

    // ****************************************
    // Bus sequencer.
    // ****************************************
    host_port_pkg::bus_state_t state_q;
    host_port_pkg::bus_state_t state_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic wr_commit;
    logic [7:0] mem_rdata;
    logic [7:0] glb_rdata;
    logic [7:0] int_mask_q;
    logic [7:0] bcast_q;
    logic [7:0] int_src;

    always_comb begin
        int_src = chan_irq_i & int_mask_q;
        case (addr_q)
            `GLB_INT_SRC: glb_rdata = int_src;
            `GLB_INT_MASK: glb_rdata = int_mask_q;
            `GLB_BCAST: glb_rdata = bcast_q;
            default: glb_rdata = 8'h00;
        endcase
    end

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        data_d = data_q;
        wr_commit = 1'b0;
        case (state_q)
            host_port_pkg::ST_IDLE: begin
                if (rd_start) begin
                    addr_d = addr_i;
                    state_d = host_port_pkg::ST_RD_FETCH;
                end else if (wr_start) begin
                    state_d = host_port_pkg::ST_WR_WAIT;
                end
            end
            host_port_pkg::ST_RD_FETCH: begin
                if (addr_q[`GLOBAL_BIT]) begin
                    data_d = glb_rdata;
                end else begin
                    data_d = mem_rdata;
                end
                state_d = rd_lvl ? host_port_pkg::ST_RD_DRIVE : host_port_pkg::ST_IDLE;
            end
            host_port_pkg::ST_RD_DRIVE: begin
                if (!rd_lvl) begin
                    state_d = host_port_pkg::ST_IDLE;
                end
            end
            host_port_pkg::ST_WR_WAIT: begin
                if (!wr_lvl) begin
                    wr_commit = 1'b1;
                    state_d = host_port_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = host_port_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= host_port_pkg::ST_IDLE;
            addr_q <= 8'h00;
            data_q <= 8'h00;
        end else if (ce_i) begin
            state_q <= state_d;
            addr_q <= addr_d;
            data_q <= data_d;
        end
    end

    always_comb begin
        data_o = data_q;
        data_oe_o = (state_q == host_port_pkg::ST_RD_DRIVE) && rd_lvl;
    end

    // ****************************************
    // Write decode and global registers.
    // ****************************************
    logic [CHANNELS-1:0] chan_wr_en;
    logic [7:0] int_mask_d;
    logic [7:0] bcast_d;
    logic wr_valid_d;
    logic [CHANNELS-1:0] wr_chan_mask_d;
    logic [3:0] wr_reg_d;
    logic [7:0] wr_data_d;
    logic irq_oe_d;
    logic irq_oe_q;

    always_comb begin
        int_mask_d = int_mask_q;
        bcast_d = bcast_q;
        chan_wr_en = '0;
        if (wr_commit && addr_i[`GLOBAL_BIT]) begin
            if (addr_i == `GLB_INT_MASK) begin
                int_mask_d = data_i;
            end
            if (addr_i == `GLB_BCAST) begin
                bcast_d = data_i;
            end
        end else if (wr_commit) begin
            if (bcast_q[`BCAST_EN_BIT]) begin
                chan_wr_en = '1;
            end else begin
                chan_wr_en[addr_i[`CHAN_MSB:`CHAN_LSB]] = 1'b1;
            end
        end
        wr_valid_d = |chan_wr_en;
        wr_chan_mask_d = chan_wr_en;
        wr_reg_d = addr_i[`REG_IDX_MSB:`REG_IDX_LSB];
        wr_data_d = data_i;
        irq_oe_d = |int_src;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_mask_q <= `INT_MASK_RST;
            bcast_q <= `BCAST_RST;
            wr_valid_o <= 1'b0;
            wr_chan_mask_o <= '0;
            wr_reg_o <= 4'h0;
            wr_data_o <= 8'h00;
            irq_oe_q <= 1'b0;
        end else if (ce_i) begin
            int_mask_q <= int_mask_d;
            bcast_q <= bcast_d;
            wr_valid_o <= wr_valid_d;
            wr_chan_mask_o <= wr_chan_mask_d;
            wr_reg_o <= wr_reg_d;
            wr_data_o <= wr_data_d;
            irq_oe_q <= irq_oe_d;
        end
    end

    always_comb begin
        irq_n_o = 1'b0;
        irq_n_oe_o = irq_oe_q;
    end

    // ****************************************
    // Channel register storage.
    // ****************************************
    chan_reg_bank #(
        .CHANNELS(CHANNELS),
        .REGS(REGS),
        .W(8)
    ) u_bank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wr_en_i(chan_wr_en),
        .wr_idx_i(addr_i[`REG_IDX_MSB:`REG_IDX_LSB]),
        .wr_data_i(data_i),
        .rd_chan_i(addr_i[`CHAN_MSB:`CHAN_LSB]),
        .rd_idx_i(addr_i[`REG_IDX_MSB:`REG_IDX_LSB]),
        .rd_data_o(mem_rdata)
    );

endmodule

`default_nettype wire

/* host_port_params.svh */
// How it works
// - Address bits three to zero pick one of sixteen registers of a channel.
// - Address bits six to four pick one of eight channels.
// - Address bit seven steers the access to the global registers.
// - The eight-bit data bus is driven only in reads and sampled in writes.
// - Mode high: a falling read strobe fetches the byte and drives it out.
// - Mode high: write strobe falling starts a write, rising loads the byte.
// - Mode low: the write strobe pin is direction, high read, low write.
// - Mode high: chip select low enables, strobes are ignored otherwise.
// - Mode low: chip select low is the access strobe for read or write.
// - One open-drain active-low interrupt line only pulls low or releases.
// - A global register shows pending interrupts of the channels enabled in the mask register.
// - One write can configure every channel at once.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

`define REG_IDX_LSB 0
`define REG_IDX_MSB 3
`define CHAN_LSB 4
`define CHAN_MSB 6
`define GLOBAL_BIT 7

`define GLB_INT_SRC 8'h80
`define GLB_INT_MASK 8'h81
`define GLB_BCAST 8'h82

`define INT_MASK_RST 8'hFF
`define BCAST_RST 8'h00
`define BCAST_EN_BIT 0

`endif

/* host_port_pkg.sv */
package host_port_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD_FETCH = 2'b01,
        ST_RD_DRIVE = 2'b10,
        ST_WR_WAIT = 2'b11
    } bus_state_t;

endpackage

/* chan_reg_bank.sv */
`timescale 1ns/1ns
`default_nettype none

module chan_reg_bank #(
    parameter int CHANNELS = 8,
    parameter int REGS = 16,
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [CHANNELS-1:0] wr_en_i,
    input wire logic [$clog2(REGS)-1:0] wr_idx_i,
    input wire logic [W-1:0] wr_data_i,
    input wire logic [$clog2(CHANNELS)-1:0] rd_chan_i,
    input wire logic [$clog2(REGS)-1:0] rd_idx_i,
    output logic [W-1:0] rd_data_o
);

    // ****************************************
    // Elaboration check.
    // ****************************************
    if (CHANNELS < 2 || REGS < 2) begin : g_bad_size
        $error("The bank needs at least two channels of at least two registers.");
    end

    // ****************************************
    // Storage, one bank per channel.
    // ****************************************
    logic [W-1:0] word [CHANNELS];
    logic [W-1:0] rd_data_d;

    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        logic [W-1:0] mem_q [REGS];
        always_ff @(posedge clk_i) begin
            if (ce_i && wr_en_i[c]) begin
                mem_q[wr_idx_i] <= wr_data_i;
            end
        end
        assign word[c] = mem_q[rd_idx_i];
    end

    // ****************************************
    // Registered read port.
    // ****************************************
    always_comb begin
        rd_data_d = word[rd_chan_i];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else if (ce_i) begin
            rd_data_o <= rd_data_d;
        end
    end

endmodule

`default_nettype wire

/* host_port_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checks.
// ****
module host_port_props #(
    parameter int CHANNELS = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bus_mode_i,
    input wire logic cs_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic data_oe_o,
    input wire logic [CHANNELS-1:0] chan_irq_i,
    input wire logic irq_n_o,
    input wire logic irq_n_oe_o,
    input wire logic wr_valid_o,
    input wire logic [CHANNELS-1:0] wr_chan_mask_o
);
    wire rl = !cs_n_i && (bus_mode_i ? !read_strobe_n_i : write_strobe_n_i);
    wire wl = !cs_n_i && !write_strobe_n_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    oe_in_read_a: assert property (data_oe_o |-> rl) else $error("drive outside read");
    oe_delay_a: assert property (data_oe_o |-> $past(rl) && $past(rl, 2))
        else $error("drive too early");
    oe_cs_a: assert property (cs_n_i |-> !data_oe_o) else $error("drive unselected");
    irq_drain_a: assert property (!irq_n_o) else $error("irq drives high");
    irq_idle_a: assert property ($past(chan_irq_i) == '0 |-> !irq_n_oe_o)
        else $error("irq without cause");
    wr_pulse_a: assert property (wr_valid_o |=> !wr_valid_o) else $error("long pulse");
    wr_commit_a: assert property (wr_valid_o |-> !$past(wl) && $past(wl, 2))
        else $error("write not at release");
    wr_chan_a: assert property (wr_valid_o |-> $onehot(wr_chan_mask_o) || &wr_chan_mask_o)
        else $error("bad channel mask");
    cover property (data_oe_o);
    cover property (wr_valid_o && &wr_chan_mask_o);
    cover property (irq_n_oe_o);
endmodule
bind octal_host_port host_port_props #(.CHANNELS(CHANNELS)) u_host_port_props (
    .clk_i(clk_i), .rst_i(rst_i), .bus_mode_i(bus_mode_i), .cs_n_i(cs_n_i),
    .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
    .data_oe_o(data_oe_o), .chan_irq_i(chan_irq_i), .irq_n_o(irq_n_o),
    .irq_n_oe_o(irq_n_oe_o), .wr_valid_o(wr_valid_o), .wr_chan_mask_o(wr_chan_mask_o)
);
`default_nettype wire

/* host_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
    input wire logic clk_i,
    input wire logic mode_i,
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [7:0] addr_o,
    output logic [7:0] bus_o
);
    logic [7:0] wd = 8'h00;
    logic drv = 1'b0;
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 8'h00;
    end
    // A released bus shows the inverse of the last host byte.
    assign bus_o = dev_oe_i ? dev_data_i : (drv ? wd : ~wd);
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic oe);
        @(negedge clk_i);
        addr_o = a;
        wd = d;
        drv = w;
        rd_n_o = !(mode_i && !w);
        wr_n_o = !w;
        cs_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        q = dev_data_i;
        oe = dev_oe_i;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        @(negedge clk_i);
        drv = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

/* octal_uart_host_bus_port_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module octal_uart_host_bus_port_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bus_mode_i = 1'b1;
    logic [7:0] chan_irq_i = 8'h00;
    logic ce = 1'b1;
    logic cs_n, rd_n, wr_n, data_oe_o, irq_n_o, irq_n_oe_o, wr_valid_o, oe;
    logic [7:0] addr, bus, data_o, wr_chan_mask_o, wr_data_o, q, w_mask, w_reg, w_data;
    logic [3:0] wr_reg_o;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    wire irq_line = irq_n_oe_o ? irq_n_o : 1'b1;
    always #4 clk_i = ~clk_i;
    octal_host_port u_octal_host_port (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .bus_mode_i(bus_mode_i), .addr_i(addr), .data_i(bus), .data_o(data_o),
        .data_oe_o(data_oe_o), .cs_n_i(cs_n), .read_strobe_n_i(rd_n),
        .write_strobe_n_i(wr_n), .chan_irq_i(chan_irq_i), .irq_n_o(irq_n_o),
        .irq_n_oe_o(irq_n_oe_o), .wr_valid_o(wr_valid_o), .wr_chan_mask_o(wr_chan_mask_o),
        .wr_reg_o(wr_reg_o), .wr_data_o(wr_data_o));
    host_bus_model u_host_bus_model (.clk_i(clk_i), .mode_i(bus_mode_i),
        .dev_data_i(data_o), .dev_oe_i(data_oe_o), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .addr_o(addr), .bus_o(bus));
    always @(posedge clk_i) begin
        cycles++;
        if (wr_valid_o) begin
            w_mask <= wr_chan_mask_o;
            w_reg <= {4'h0, wr_reg_o};
            w_data <= wr_data_o;
        end
        if (cycles == 4000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_host_bus_model.acc(1'b0, a, 8'h00, q, oe);
        chk(q, e);
        chk({7'h00, oe}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        w_mask = 8'h00;
        u_host_bus_model.acc(1'b1, a, d, q, oe);
    endtask
    task automatic do_reset(input logic m);
        @(negedge clk_i);
        rst_i = 1'b1;
        bus_mode_i = m;
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
    endtask
    task automatic t_reset();
        rd(8'h81, 8'hFF);
        rd(8'h82, 8'h00);
        rd(8'h85, 8'h00);
        chk({7'h00, irq_line}, 8'h01);
        $display("t_reset done");
    endtask
    task automatic t_chan();
        for (int i = 0; i < 8; i++) begin
            wr({1'b0, 3'(i), 4'hA}, 8'(8'h10 + i));
            chk(w_mask, 8'(8'h01 << i));
            chk(w_reg, 8'h0A);
            chk(w_data, 8'(8'h10 + i));
        end
        wr(8'h05, 8'hEE);
        for (int i = 0; i < 8; i++) rd({1'b0, 3'(i), 4'hA}, 8'(8'h10 + i));
        rd(8'h05, 8'hEE);
        $display("t_chan done");
    endtask
    task automatic t_irq();
        wr(8'h81, 8'h05);
        chan_irq_i = 8'h06;
        repeat (2) @(negedge clk_i);
        chk({7'h00, irq_line}, 8'h00);
        rd(8'h80, 8'h04);
        wr(8'h80, 8'hFF);
        rd(8'h80, 8'h04);
        chan_irq_i = 8'h02;
        repeat (2) @(negedge clk_i);
        chk({7'h00, irq_line}, 8'h01);
        rd(8'h80, 8'h00);
        chan_irq_i = 8'h00;
        $display("t_irq done");
    endtask
    task automatic t_bcast();
        wr(8'h82, 8'h01);
        wr(8'h03, 8'h5A);
        chk(w_mask, 8'hFF);
        rd(8'h53, 8'h5A);
        rd(8'h73, 8'h5A);
        wr(8'h82, 8'h00);
        wr(8'h13, 8'h77);
        chk(w_mask, 8'h02);
        $display("t_bcast done");
    endtask
    task automatic t_freeze();
        ce = 1'b0;
        wr(8'h23, 8'h99);
        chk(w_mask, 8'h00);
        ce = 1'b1;
        rd(8'h23, 8'h5A);
        $display("t_freeze done");
    endtask
    task automatic t_mode0();
        do_reset(1'b0);
        wr(8'h12, 8'hC3);
        chk(w_mask, 8'h02);
        rd(8'h12, 8'hC3);
        rd(8'h81, 8'hFF);
        $display("t_mode0 done");
    endtask
    initial begin
        do_reset(1'b1);
        t_reset();
        t_chan();
        t_irq();
        t_bcast();
        t_freeze();
        t_mode0();
        give_verdict();
    end
endmodule
`default_nettype wire
